// ==== include/dma_ctrl_pkg.sv ====
// Constants, register map and carrier types for the DMA global control block
// How it works
// - Each channel register except the read-only pointers also answers at +0x4 clear, +0x8 set, +0xC toggle.
// - Controller control bit 15 enables the whole module; zero disables it.
// - Controller control bit 12 suspends transfers, freeing the data bus.
// - Controller control bit 11 reads one only while the module moves data.
// - A suspend change lets the current bus transaction finish first.
// - Unimplemented bits read zero; channel registers reset zero, event control FF00.
package dma_ctrl_pkg;

  // Register byte offsets within the block
  localparam logic [15:0] CTRL_OFS  = 16'h1000;
  localparam logic [15:0] ECON_OFS  = 16'h15B0;
  localparam logic [15:0] INT_OFS   = 16'h15C0;
  localparam logic [15:0] SSA_OFS   = 16'h15D0;
  localparam logic [15:0] DSA_OFS   = 16'h15F0;
  localparam logic [15:0] SSIZ_OFS  = 16'h15F0;
  localparam logic [15:0] DSIZ_OFS  = 16'h1600;
  localparam logic [15:0] SPTR_OFS  = 16'h1610;
  localparam logic [15:0] DPTR_OFS  = 16'h1620;
  localparam logic [15:0] CSIZ_OFS  = 16'h1630;
  localparam logic [15:0] CPTR_OFS  = 16'h1640;
  localparam logic [15:0] DAT_OFS   = 16'h1650;

  // Alias codes in address bits 3:2
  localparam logic [1:0] ALIAS_WRITE = 2'h0;
  localparam logic [1:0] ALIAS_CLEAR = 2'h1;
  localparam logic [1:0] ALIAS_SET   = 2'h2;
  localparam logic [1:0] ALIAS_TOGGLE = 2'h3;

  // Controller control fields
  localparam int CTRL_ON_BIT      = 15;
  localparam int CTRL_SUSPEND_BIT = 12;
  localparam int CTRL_BUSY_BIT    = 11;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_9000;

  // Event control fields
  localparam int ECON_FORCE_BIT = 7;
  localparam int ECON_ABORT_BIT = 6;
  localparam int ECON_SIRQEN_BIT = 4;
  localparam int ECON_IRQ_LSB   = 8;
  localparam logic [31:0] ECON_WMASK = 32'h0000_FFF8;
  localparam logic [31:0] ECON_RESET = 32'h0000_FF00;

  // Interrupt control fields: enables 23:16, flags 7:0
  localparam logic [31:0] INT_WMASK   = 32'h00FF_00FF;
  localparam int INT_CELL_DONE_BIT  = 2;
  localparam int INT_BLOCK_DONE_BIT = 3;
  localparam int INT_DEST_DONE_BIT  = 5;
  localparam int INT_ABORT_BIT      = 1;

  localparam logic [31:0] HALF_MASK = 32'h0000_FFFF;
  localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Software register access
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } reg_req_type;

  // Data bus transaction request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_READ, ST_WRITE} eng_state_type;

endpackage

// ==== design/dma_global_control_regs.sv ====
// DMA global control register block with channel 7 register map and transfer engine
`timescale 1ns/1ps
module dma_global_control_regs #(
  parameter int IRQ_LINES = 256
) (
  input  wire logic                       clk,        // System clock, 250 MHz
  input  wire logic                       resetn,     // Asynchronous reset, active low
  input  wire dma_ctrl_pkg::reg_req_type  reg_in,     // Register access request
  output logic [31:0]                     reg_rdata,  // Read data, one cycle after rd
  input  wire logic [IRQ_LINES-1:0]       start_irq,  // Start event lines
  output dma_ctrl_pkg::mem_req_type       mem_out,    // Data bus request
  input  wire logic                       mem_ack,    // Data bus transaction done
  input  wire logic [31:0]                mem_rdata   // Data bus read data
);

  // The 8-bit start selector must be able to reach every start line
  if (IRQ_LINES != 256) begin : irq_lines_check
    $error("IRQ_LINES must be 256 for an 8-bit start selector");
  end

  logic [31:0] ctrl_reg, econ_reg, int_reg, ssa_reg, dsa_reg, ssiz_reg, dsiz_reg;
  logic [31:0] sptr_reg, dptr_reg, csiz_reg, cptr_reg, dat_reg, data_reg;
  logic [31:0] ctrl_next, econ_next, int_next, ssa_next, dsa_next, ssiz_next, dsiz_next;
  logic [31:0] csiz_next, dat_next;
  logic [31:0] econ_hw;
  dma_ctrl_pkg::eng_state_type state_reg, state_next;

  // Address decode: base register and alias code
  wire [15:0] base_addr = {reg_in.addr[15:4], 4'h0};
  wire [1:0]  alias_op  = reg_in.addr[3:2];
  wire        wr_ctrl   = reg_in.wr && base_addr == dma_ctrl_pkg::CTRL_OFS;
  wire        wr_econ   = reg_in.wr && base_addr == dma_ctrl_pkg::ECON_OFS;
  wire        wr_int    = reg_in.wr && base_addr == dma_ctrl_pkg::INT_OFS;
  wire        wr_ssa    = reg_in.wr && base_addr == dma_ctrl_pkg::SSA_OFS;
  wire        wr_dsa    = reg_in.wr && base_addr == dma_ctrl_pkg::DSA_OFS;
  wire        wr_ssiz   = reg_in.wr && base_addr == dma_ctrl_pkg::SSIZ_OFS;
  wire        wr_dsiz   = reg_in.wr && base_addr == dma_ctrl_pkg::DSIZ_OFS;
  wire        wr_csiz   = reg_in.wr && base_addr == dma_ctrl_pkg::CSIZ_OFS;
  wire        wr_dat    = reg_in.wr && base_addr == dma_ctrl_pkg::DAT_OFS;

  // Alias write: plain, clear, set or toggle the written ones, within the writable mask
  function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [1:0] op, input logic [31:0] mask);
    logic [31:0] val;
    case (op)
      dma_ctrl_pkg::ALIAS_WRITE: val = wd;
      dma_ctrl_pkg::ALIAS_CLEAR: val = old & ~wd;
      dma_ctrl_pkg::ALIAS_SET:   val = old | wd;
      default:                   val = old ^ wd;
    endcase
    return (old & ~mask) | (val & mask);
  endfunction

  // Global enable and suspend
  wire module_on     = ctrl_reg[dma_ctrl_pkg::CTRL_ON_BIT];
  wire suspend_req   = ctrl_reg[dma_ctrl_pkg::CTRL_SUSPEND_BIT];
  wire may_transfer  = module_on && !suspend_req;
  wire in_bus_cycle  = state_reg == dma_ctrl_pkg::ST_READ || state_reg == dma_ctrl_pkg::ST_WRITE;
  // Busy while a transaction is in flight or the engine is allowed to move data
  wire module_active_flag = in_bus_cycle ||
                            (state_reg == dma_ctrl_pkg::ST_RUN && may_transfer);

  // Start conditions from the event control register
  wire [7:0] irq_sel    = econ_reg[dma_ctrl_pkg::ECON_IRQ_LSB +: 8];
  wire       irq_start  = econ_reg[dma_ctrl_pkg::ECON_SIRQEN_BIT] && start_irq[irq_sel];
  wire       force_start = econ_reg[dma_ctrl_pkg::ECON_FORCE_BIT];
  wire       abort_req  = econ_reg[dma_ctrl_pkg::ECON_ABORT_BIT];
  wire       start_go   = module_on && state_reg == dma_ctrl_pkg::ST_IDLE &&
                          (force_start || irq_start);

  // Completion of one unit moved
  wire        write_done = state_reg == dma_ctrl_pkg::ST_WRITE && mem_ack;
  wire [15:0] sptr_inc   = sptr_reg[15:0] + 16'h0001;
  wire [15:0] dptr_inc   = dptr_reg[15:0] + 16'h0001;
  wire [15:0] cptr_inc   = cptr_reg[15:0] + 16'h0001;
  wire        src_wrap   = sptr_inc >= ssiz_reg[15:0];
  wire        dst_full   = dptr_inc >= dsiz_reg[15:0];
  wire        cell_full  = cptr_inc >= csiz_reg[15:0];
  wire        block_end  = write_done && dst_full;
  wire        cell_end   = write_done && (cell_full || dst_full);
  wire        abort_now  = abort_req && state_reg == dma_ctrl_pkg::ST_RUN;

  // Engine sequencing; gates are checked only between transactions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dma_ctrl_pkg::ST_IDLE:  if (start_go) state_next = dma_ctrl_pkg::ST_RUN;
      dma_ctrl_pkg::ST_RUN: begin
        if (abort_now) state_next = dma_ctrl_pkg::ST_IDLE;
        else if (may_transfer) state_next = dma_ctrl_pkg::ST_READ;
      end
      dma_ctrl_pkg::ST_READ:  if (mem_ack) state_next = dma_ctrl_pkg::ST_WRITE;
      dma_ctrl_pkg::ST_WRITE: begin
        if (mem_ack) state_next = cell_end ? dma_ctrl_pkg::ST_IDLE : dma_ctrl_pkg::ST_RUN;
      end
      default: state_next = dma_ctrl_pkg::ST_IDLE;
    endcase
  end

  // Software writes through the alias decode
  assign ctrl_next = wr_ctrl ? apply(ctrl_reg, reg_in.wdata, alias_op,
                                     dma_ctrl_pkg::CTRL_WMASK) : ctrl_reg;
  assign ssa_next  = wr_ssa ? apply(ssa_reg, reg_in.wdata, alias_op,
                                    dma_ctrl_pkg::WORD_MASK) : ssa_reg;
  assign dsa_next  = wr_dsa ? apply(dsa_reg, reg_in.wdata, alias_op,
                                    dma_ctrl_pkg::WORD_MASK) : dsa_reg;
  assign ssiz_next = wr_ssiz ? apply(ssiz_reg, reg_in.wdata, alias_op,
                                     dma_ctrl_pkg::HALF_MASK) : ssiz_reg;
  assign dsiz_next = wr_dsiz ? apply(dsiz_reg, reg_in.wdata, alias_op,
                                     dma_ctrl_pkg::HALF_MASK) : dsiz_reg;
  assign csiz_next = wr_csiz ? apply(csiz_reg, reg_in.wdata, alias_op,
                                     dma_ctrl_pkg::HALF_MASK) : csiz_reg;
  assign dat_next  = wr_dat ? apply(dat_reg, reg_in.wdata, alias_op,
                                    dma_ctrl_pkg::HALF_MASK) : dat_reg;

  // Event control: hardware clears force and abort when taken; a software write in the
  // same cycle lands on top, so a fresh request is never lost
  always_comb begin
    econ_hw = econ_reg;
    if (start_go) econ_hw[dma_ctrl_pkg::ECON_FORCE_BIT] = 1'b0;
    if (abort_now) econ_hw[dma_ctrl_pkg::ECON_ABORT_BIT] = 1'b0;
    econ_next = wr_econ ? apply(econ_hw, reg_in.wdata, alias_op,
                                dma_ctrl_pkg::ECON_WMASK) : econ_hw;
  end

  // Interrupt flags: a hardware set in the same cycle beats a software clear
  always_comb begin
    int_next = wr_int ? apply(int_reg, reg_in.wdata, alias_op,
                              dma_ctrl_pkg::INT_WMASK) : int_reg;
    if (cell_end) int_next[dma_ctrl_pkg::INT_CELL_DONE_BIT] = 1'b1;
    if (block_end) int_next[dma_ctrl_pkg::INT_BLOCK_DONE_BIT] = 1'b1;
    if (block_end) int_next[dma_ctrl_pkg::INT_DEST_DONE_BIT] = 1'b1;
    if (abort_now) int_next[dma_ctrl_pkg::INT_ABORT_BIT] = 1'b1;
  end

  // Read mux; alias addresses and unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = dma_ctrl_pkg::ZERO_WORD;
    if (alias_op == dma_ctrl_pkg::ALIAS_WRITE) begin
      case (base_addr)
        dma_ctrl_pkg::CTRL_OFS: begin
          rd_mux = ctrl_reg;
          rd_mux[dma_ctrl_pkg::CTRL_BUSY_BIT] = module_active_flag;
        end
        dma_ctrl_pkg::ECON_OFS: rd_mux = econ_reg;
        dma_ctrl_pkg::INT_OFS:  rd_mux = int_reg;
        dma_ctrl_pkg::SSA_OFS:  rd_mux = ssa_reg;
        dma_ctrl_pkg::DSA_OFS:  rd_mux = dsa_reg;
        dma_ctrl_pkg::DSIZ_OFS: rd_mux = dsiz_reg;
        dma_ctrl_pkg::SPTR_OFS: rd_mux = sptr_reg;
        dma_ctrl_pkg::DPTR_OFS: rd_mux = dptr_reg;
        dma_ctrl_pkg::CSIZ_OFS: rd_mux = csiz_reg;
        dma_ctrl_pkg::CPTR_OFS: rd_mux = cptr_reg;
        dma_ctrl_pkg::DAT_OFS:  rd_mux = dat_reg;
        default:                rd_mux = dma_ctrl_pkg::ZERO_WORD;
      endcase
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= dma_ctrl_pkg::ZERO_WORD;
      econ_reg <= dma_ctrl_pkg::ECON_RESET;
      int_reg  <= dma_ctrl_pkg::ZERO_WORD;
      ssa_reg  <= dma_ctrl_pkg::ZERO_WORD;
      dsa_reg  <= dma_ctrl_pkg::ZERO_WORD;
      ssiz_reg <= dma_ctrl_pkg::ZERO_WORD;
      dsiz_reg <= dma_ctrl_pkg::ZERO_WORD;
      csiz_reg <= dma_ctrl_pkg::ZERO_WORD;
      dat_reg  <= dma_ctrl_pkg::ZERO_WORD;
    end else begin
      ctrl_reg <= ctrl_next;
      econ_reg <= econ_next;
      int_reg  <= int_next;
      ssa_reg  <= ssa_next;
      dsa_reg  <= dsa_next;
      ssiz_reg <= ssiz_next;
      dsiz_reg <= dsiz_next;
      csiz_reg <= csiz_next;
      dat_reg  <= dat_next;
    end
  end

  // Engine state, pointers and read data; pointers move on a finished write and clear on an abort
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dma_ctrl_pkg::ST_IDLE;
      sptr_reg  <= dma_ctrl_pkg::ZERO_WORD;
      dptr_reg  <= dma_ctrl_pkg::ZERO_WORD;
      cptr_reg  <= dma_ctrl_pkg::ZERO_WORD;
      data_reg  <= dma_ctrl_pkg::ZERO_WORD;
      reg_rdata <= dma_ctrl_pkg::ZERO_WORD;
    end else begin
      state_reg <= state_next;
      if (reg_in.rd) reg_rdata <= rd_mux;
      if (state_reg == dma_ctrl_pkg::ST_READ && mem_ack) data_reg <= mem_rdata;
      if (write_done) begin
        sptr_reg <= {16'h0000, (src_wrap || dst_full) ? 16'h0000 : sptr_inc};
        dptr_reg <= {16'h0000, dst_full ? 16'h0000 : dptr_inc};
        cptr_reg <= {16'h0000, cell_end ? 16'h0000 : cptr_inc};
      end else if (abort_now) begin
        sptr_reg <= dma_ctrl_pkg::ZERO_WORD;
        dptr_reg <= dma_ctrl_pkg::ZERO_WORD;
        cptr_reg <= dma_ctrl_pkg::ZERO_WORD;
      end
    end
  end

  // Data bus request from the engine state
  assign mem_out.req   = in_bus_cycle;
  assign mem_out.we    = state_reg == dma_ctrl_pkg::ST_WRITE;
  assign mem_out.addr  = (state_reg == dma_ctrl_pkg::ST_WRITE) ? dsa_reg + dptr_reg
                                                               : ssa_reg + sptr_reg;
  assign mem_out.wdata = data_reg;

endmodule

// ==== verif/dma_global_control_regs_monitor.sv ====
// Concurrent checks on the DMA global control block ports
`timescale 1ns/1ps
module dma_ctrl_monitor #(
  parameter int IRQ_LINES = 256
) (
  input wire logic                      clk,       // System clock
  input wire logic                      resetn,    // Reset, active low
  input wire dma_ctrl_pkg::reg_req_type reg_in,    // Register request
  input wire logic [31:0]               reg_rdata, // Read data
  input wire logic [IRQ_LINES-1:0]      start_irq, // Start events
  input wire dma_ctrl_pkg::mem_req_type mem_out,   // Bus request
  input wire logic                      mem_ack,   // Bus done
  input wire logic [31:0]               mem_rdata  // Bus read data
);
  logic [31:0] ctl_reg;
  logic [31:0] dat_reg;
  // Register slot and read decode
  wire ctl_hit = reg_in.addr[15:4] == dma_ctrl_pkg::CTRL_OFS[15:4];
  wire dat_hit = reg_in.addr[15:4] == dma_ctrl_pkg::DAT_OFS[15:4];
  wire rd_ctl  = reg_in.rd && reg_in.addr == dma_ctrl_pkg::CTRL_OFS;
  wire rd_dat  = reg_in.rd && reg_in.addr == dma_ctrl_pkg::DAT_OFS;
  function automatic logic [31:0] upd(logic [31:0] o, logic [1:0] k, logic [31:0] v);
    return k == 2'h0 ? v : k == 2'h1 ? o & ~v : k == 2'h2 ? o | v : o ^ v;
  endfunction
  // Shadow of what software wrote, aliases included
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= 32'h0000_0000;
      dat_reg <= 32'h0000_0000;
    end else if (reg_in.wr && ctl_hit) begin
      ctl_reg <= upd(ctl_reg, reg_in.addr[3:2], reg_in.wdata) & dma_ctrl_pkg::CTRL_WMASK;
    end else if (reg_in.wr && dat_hit) begin
      dat_reg <= upd(dat_reg, reg_in.addr[3:2], reg_in.wdata) & dma_ctrl_pkg::HALF_MASK;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  on_gate_a: assert property ($rose(mem_out.req) |-> $past(ctl_reg[15]))
    else $error("bus request while module off");
  off_quiet_a: assert property (!ctl_reg[15] && !mem_out.req |=> !mem_out.req)
    else $error("transfer started while module off");
  suspend_gate_a: assert property ($rose(mem_out.req) |-> !$past(ctl_reg[12]))
    else $error("bus request while suspended");
  req_hold_a: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr))
    else $error("bus request dropped before its answer");
  ctl_read_a: assert property (rd_ctl |=> (reg_rdata & ~32'h0000_0800) == ctl_reg)
    else $error("control readback wrong");
  busy_on_a: assert property (rd_ctl && mem_out.req |=> reg_rdata[11])
    else $error("busy bit low during a transfer");
  busy_off_a: assert property (rd_ctl && !ctl_reg[15] && !mem_out.req |=> !reg_rdata[11])
    else $error("busy bit high while module off");
  alias_data_a: assert property (rd_dat |=> reg_rdata == dat_reg)
    else $error("pattern data readback wrong");
  // Main scenarios reached
  ack_c: cover property (mem_out.req && mem_ack);
  susp_c: cover property (mem_out.req && ctl_reg[12]);
  toggle_c: cover property (reg_in.wr && dat_hit && reg_in.addr[3:2] == 2'h3);
endmodule
bind dma_global_control_regs dma_ctrl_monitor #(.IRQ_LINES(IRQ_LINES)) mon_u (
  .clk(clk), .resetn(resetn), .reg_in(reg_in), .reg_rdata(reg_rdata),
  .start_irq(start_irq), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

// ==== verif/mem_partner.sv ====
// Behavioural data bus memory for the DMA engine
`timescale 1ns/1ps
module mem_partner (
  input  wire logic                      clk,      // System clock
  input  wire logic                      resetn,   // Reset, active low
  input  wire dma_ctrl_pkg::mem_req_type mem_in,   // Engine request
  input  wire logic                      slow,     // Answer late
  output logic                           mem_ack,  // Transaction done
  output logic [31:0]                    mem_rdata // Read data
);
  logic [3:0]  wait_reg;
  logic [31:0] junk_reg;
  // Ack after one or six cycles; between answers the data lines churn
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 4'h0;
      mem_ack  <= 1'b0;
      junk_reg <= 32'h0000_0000;
    end else begin
      junk_reg <= junk_reg + 32'h9E37_79B9;
      mem_ack  <= mem_in.req && !mem_ack && wait_reg >= (slow ? 4'h5 : 4'h0);
      wait_reg <= (mem_in.req && !mem_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
  assign mem_rdata = mem_ack ? {16'hC0DE, mem_in.addr[15:0]} : ~junk_reg;
endmodule

// ==== verif/test_dma_global_control_regs.sv ====
// Self-checking bench for the DMA global control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module test_dma_global_control_regs;
  localparam int IRQ_LINES = 256;
  localparam logic [15:0] CTL  = dma_ctrl_pkg::CTRL_OFS;
  localparam logic [15:0] DAT  = dma_ctrl_pkg::DAT_OFS;
  localparam logic [15:0] ECON = dma_ctrl_pkg::ECON_OFS;
  localparam logic [15:0] SSA  = dma_ctrl_pkg::SSA_OFS;
  logic                      clk = 1'b0;
  logic                      resetn = 1'b0;
  logic                      slow = 1'b0;
  logic                      mem_ack;
  logic [IRQ_LINES-1:0]      start_irq = '0;
  logic [31:0]               got_word = 32'h0000_0000;
  logic [31:0]               reg_rdata, mem_rdata, rv, ex, m;
  dma_ctrl_pkg::reg_req_type reg_in = 50'h0;
  dma_ctrl_pkg::mem_req_type mem_out;
  int                        num_errors = 0;
  int                        compares = 0;
  logic [15:0]               ofs [12] = '{ECON, dma_ctrl_pkg::INT_OFS, SSA,
    dma_ctrl_pkg::SSIZ_OFS, dma_ctrl_pkg::DSIZ_OFS, dma_ctrl_pkg::SPTR_OFS,
    dma_ctrl_pkg::DPTR_OFS, dma_ctrl_pkg::CSIZ_OFS, dma_ctrl_pkg::CPTR_OFS, DAT, CTL, 16'h1FF0};
  dma_global_control_regs #(.IRQ_LINES(IRQ_LINES)) dut_u (.clk(clk), .resetn(resetn),
    .reg_in(reg_in), .reg_rdata(reg_rdata), .start_irq(start_irq), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mem_partner mem_u (.clk(clk), .resetn(resetn), .mem_in(mem_out), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Clock and random far-side pace
  always #2 clk = ~clk;
  always @(posedge clk) begin
    #1 slow = 1'($urandom());
    start_irq = IRQ_LINES'($urandom());
  end
  // Every write carries the word the partner returned on the read before it
  always @(negedge clk) begin
    if (resetn && mem_ack && mem_out.req) begin
      if (!mem_out.we) got_word = mem_rdata;
      else `CHK("moved word", got_word, mem_out.wdata)
    end
  end
  // Register write and read cycles
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) #1 reg_in = '{a, 1'b1, 1'b0, d};
    @(posedge clk) #1 reg_in.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk) #1 reg_in = '{a, 1'b0, 1'b1, 32'h0000_0000};
    @(posedge clk) #1 reg_in.rd = 1'b0;
    rv = reg_rdata;
  endtask
  function automatic logic [31:0] upd(logic [31:0] o, logic [1:0] k, logic [31:0] v);
    return k == 2'h0 ? v : k == 2'h1 ? o & ~v : k == 2'h2 ? o | v : o ^ v;
  endfunction
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded waits on the request line and on the busy bit
  task automatic wait_req(input logic want);
    for (int i = 0; i < 400; i++) begin
      if (mem_out.req === want) return;
      @(posedge clk) #1;
    end
    `CHK("bus request level", want, mem_out.req)
    wrap_up();
  endtask
  task automatic poll_busy(input logic want);
    for (int i = 0; i < 100; i++) begin
      rd(CTL);
      if (rv[11] === want) return;
    end
    `CHK("busy bit", want, rv[11])
    wrap_up();
  endtask
  // Watchdog on the whole run
  initial begin
    #150000;
    `CHK("run finished in time", 1'b1, 1'b0)
    wrap_up();
  end
  // Main sequence
  initial begin
    rv = $urandom(12);
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      `CHK("reset value", (i == 0 ? 32'h0000_FF00 : 32'h0000_0000), rv)
    end
    wr(CTL, 32'hFFFF_FFFF);
    rd(CTL);
    `CHK("control all ones", 32'h0000_9000, rv)
    wr(CTL + 16'h4, 32'hFFFF_FFFF);
    rd(CTL);
    `CHK("control clear place", 32'h0000_0000, rv)
    ex = 32'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      m = (k == 3) ? 32'hFFFF_FFFF : $urandom();
      ex = upd(ex, k[1:0], m) & 32'h0000_FFFF;
      wr(DAT + {k[1:0], 2'h0}, m);
      rd(DAT);
      `CHK("pattern data", ex, rv)
    end
    m = $urandom() & 32'hFFFF_FFFC;
    wr(SSA, m);
    wr(dma_ctrl_pkg::SSIZ_OFS, 32'h0000_0100);
    wr(dma_ctrl_pkg::DSIZ_OFS, 32'h0000_0100);
    wr(dma_ctrl_pkg::CSIZ_OFS, 32'h0000_0100);
    wr(ECON + 16'h8, 32'h0000_0080);
    repeat (20) begin
      @(posedge clk) #1;
      `CHK("no request while off", 1'b0, mem_out.req)
    end
    rd(SSA);
    `CHK("source address kept", m, rv)
    wr(CTL + 16'h8, 32'h0000_8000);
    wr(ECON + 16'h8, 32'h0000_0080);
    wait_req(1'b1);
    rd(CTL);
    `CHK("busy while moving", 1'b1, rv[11])
    wr(CTL + 16'h8, 32'h0000_1000);
    poll_busy(1'b0);
    repeat (30) begin
      @(posedge clk) #1;
      `CHK("quiet while suspended", 1'b0, mem_out.req)
    end
    wr(CTL + 16'h4, 32'h0000_1000);
    wait_req(1'b1);
    wr(CTL + 16'h4, 32'h0000_8000);
    poll_busy(1'b0);
    wrap_up();
  end
endmodule
